/* File: bgp_cfg.svh */
// Constants for the banked GPIO port: file addresses, field positions, reset values
`ifndef BGP_CFG_SVH
`define BGP_CFG_SVH

`define BGP_PORT_W        6
`define BGP_GPR_DEPTH     128

// Effective file addresses: {bank, in-bank address}
`define BGP_IDX_STATUS0   8'h03
`define BGP_IDX_STATUS1   8'h83
`define BGP_IDX_PORT      8'h05
`define BGP_IDX_OPTION    8'h81
`define BGP_IDX_DIR       8'h85
`define BGP_IDX_BITOP     8'h07

// General purpose storage windows and slot bases
`define BGP_GPR0_LO       8'h20
`define BGP_GPR0_HI       8'h7F
`define BGP_GPR1_LO       8'hA0
`define BGP_GPR1_HI       8'hBF
`define BGP_GPRM_LO       8'hF0
`define BGP_GPR1_BASE     8'h40
`define BGP_GPRM_BASE     8'hA0

// Wishbone address fields
`define BGP_ADR_BANK      9
`define BGP_ADR_HI        8
`define BGP_ADR_LO        2

// Status fields
`define BGP_ST_BANK       5
`define BGP_STATUS_RST    8'h18
`define BGP_STATUS_WMASK  8'hE7

// Option fields
`define BGP_OPTION_RST    8'hFF
`define BGP_OPT_PULLUP_N  7

// Direction and port values
`define BGP_DIR_RST       6'h3F
`define BGP_LATCH_POR     6'h00
`define BGP_PORT_UPPER    2'h3
`define BGP_DIR_UPPER     2'h0

// Bit operation command fields
`define BGP_BO_BIT_HI     2
`define BGP_BO_BIT_LO     0
`define BGP_BO_VAL        3
`define BGP_BO_TGT_HI     5
`define BGP_BO_TGT_LO     4

`define BGP_RD_PAD        24'h00_0000

`endif

/* File: bgp_chk.sv */
// Port checker for the banked GPIO port
`timescale 1ns/1ps
`default_nettype none
module bgp_chk
(
  // Clock and resets
  input wire logic        I_REF_CLK,
  input wire logic        I_RST,
  input wire logic        I_POR_RST,
  // Bus
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [9:0]  I_WB_ADR,
  input wire logic [3:0]  I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        O_WB_ACK,
  // Pins
  input wire logic [5:0]  I_GP,
  input wire logic [5:0]  O_GP,
  input wire logic [5:0]  O_GP_OE,
  input wire logic        O_WEAK_PULLUP_EN
);
  logic       bank_r;
  logic       wr;
  logic [7:0] idx;
  assign wr = O_WB_ACK & I_WB_WE & I_WB_SEL[0];
  assign idx = {I_WB_ADR[9] | bank_r, I_WB_ADR[8:2]};
  // Shadow of the bank bit; only plain status writes move it
  always_ff @(posedge I_REF_CLK or posedge I_RST)
    if (I_RST)
      bank_r <= 1'b0;
    else if (wr && idx[6:0] == 7'h03)
      bank_r <= I_WB_DAT[5];
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  ack_delay_a: assert property ($rose(I_WB_STB) && I_WB_CYC |=> !O_WB_ACK ##[1:2] O_WB_ACK)
    else $error("ack late");
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack too long");
  ack_req_a: assert property (O_WB_ACK |-> I_WB_CYC && I_WB_STB)
    else $error("ack without request");
  rd_pad_a: assert property (O_WB_ACK && !I_WB_WE |-> O_WB_DAT[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  port_rd_a: assert property (O_WB_ACK && !I_WB_WE && idx == 8'h05 |->
    O_WB_DAT[7:0] == {2'b11, $past(I_GP, 3)})
    else $error("port read not pins");
  dir_wr_a: assert property (wr && idx == 8'h85 |=> O_GP_OE == ~$past(I_WB_DAT[5:0]))
    else $error("enable not direction");
  port_wr_a: assert property (wr && idx == 8'h05 |=> O_GP == $past(I_WB_DAT[5:0]))
    else $error("latch not written");
  pullup_wr_a: assert property (wr && idx == 8'h81 |=>
    O_WEAK_PULLUP_EN == !$past(I_WB_DAT[7]))
    else $error("pull-up enable wrong");
  rst_val_a: assert property ($fell(I_RST) |-> O_GP_OE == 6'h00 && !O_WEAK_PULLUP_EN)
    else $error("reset outputs wrong");
  por_val_a: assert property ($fell(I_POR_RST) |-> O_GP == 6'h00)
    else $error("power-on latch wrong");
endmodule
bind bgp_gpio_port bgp_chk u_chk (.*);
`default_nettype wire

/* File: bgp_gpio_port.sv */
// Banked GPIO port register file with Wishbone slave and read-modify-write engine
// Behaviour
// - Port data reads return the synchronised pin levels, not the output latch.
// - Port data writes load the output latch, which drives output pins.
// - Every write reads the whole register, modifies it, writes it back.
// - Port read-modify-write uses pin levels as operand, result goes to latch.
// - Input bits get their pin level copied into the latch on port rewrite.
// - Unimplemented direction bits and unmapped locations read as zero.
// - Non-power-on resets keep port latch; upper two port bits read ones.
// - General registers are static storage in the map; special function registers are reset.
`timescale 1ns/1ps
`default_nettype none
`include "bgp_cfg.svh"

module bgp_gpio_port
  import bgp_pkg::*;
(
  // Clock and resets
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_POR_RST,
  // Wishbone slave
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [9:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic [31:0]      O_WB_DAT,
  output logic             O_WB_ACK,
  // Port pins
  input  wire logic [5:0]  I_GP,
  output logic [5:0]       O_GP,
  output logic [5:0]       O_GP_OE,
  // Pull-up control
  output logic             O_WEAK_PULLUP_EN
);

  bgp_state_type state_r;
  logic [7:0]    idx_r;
  logic          we_r;
  logic          sel_r;
  logic [7:0]    wdat_r;
  logic [7:0]    tgt_r;
  logic [7:0]    operand_r;
  logic [7:0]    status_r;
  logic [7:0]    option_r;
  logic [7:0]    bitop_r;
  logic [5:0]    dir_r;
  logic [7:0]    gpr_r [`BGP_GPR_DEPTH];
  logic [7:0]    tgt_c;
  logic [7:0]    rd_val;
  logic [7:0]    result_c;
  logic          commit;
  logic [7:0]    req_idx;

  bgp_pad_if pad_if ();

  function automatic logic gpr_hit(input logic [7:0] idx);
    gpr_hit = ((idx >= `BGP_GPR0_LO) && (idx <= `BGP_GPR0_HI))
           || ((idx >= `BGP_GPR1_LO) && (idx <= `BGP_GPR1_HI))
           || (idx >= `BGP_GPRM_LO);
  endfunction

  // Top of bank 1 folds onto the top of bank 0, so both reach the same cells
  function automatic logic [6:0] gpr_slot(input logic [7:0] idx);
    logic [7:0] off;
    off = idx - `BGP_GPR0_LO;
    if (idx >= `BGP_GPRM_LO)
    begin
      off = idx - `BGP_GPRM_BASE;
    end
    else if (idx >= `BGP_GPR1_LO)
    begin
      off = idx - `BGP_GPR1_BASE;
    end
    gpr_slot = off[6:0];
  endfunction

  function automatic logic is_status(input logic [7:0] idx);
    is_status = (idx == `BGP_IDX_STATUS0) || (idx == `BGP_IDX_STATUS1);
  endfunction

  function automatic logic [7:0] bitop_target(input logic [1:0] sel);
    logic [7:0] t;
    t = `BGP_IDX_STATUS0;
    case (bgp_target_type'(sel))
      BGP_TGT_PORT:   t = `BGP_IDX_PORT;
      BGP_TGT_OPTION: t = `BGP_IDX_OPTION;
      BGP_TGT_DIR:    t = `BGP_IDX_DIR;
      default:        t = `BGP_IDX_STATUS0;
    endcase
    bitop_target = t;
  endfunction

  function automatic logic [7:0] bit_apply(input logic [7:0] v,
                                           input logic [2:0] pos,
                                           input logic       val);
    logic [7:0] r;
    r      = v;
    r[pos] = val;
    bit_apply = r;
  endfunction

  // Only the low bank bit selects; the reserved bits are stored but ignored
  assign req_idx = {I_WB_ADR[`BGP_ADR_BANK] | status_r[`BGP_ST_BANK],
                    I_WB_ADR[`BGP_ADR_HI:`BGP_ADR_LO]};

  // Request sequencing: take, read operand, answer and write back
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_r <= BGP_IDLE;
    end
    else
    begin
      case (state_r)
        BGP_IDLE:
        begin
          if (I_WB_CYC && I_WB_STB)
          begin
            state_r <= BGP_OPER;
          end
        end
        BGP_OPER:
        begin
          state_r <= BGP_ACK;
        end
        default:
        begin
          state_r <= BGP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      idx_r  <= 8'h00;
      we_r   <= 1'b0;
      sel_r  <= 1'b0;
      wdat_r <= 8'h00;
    end
    else if ((state_r == BGP_IDLE) && I_WB_CYC && I_WB_STB)
    begin
      idx_r  <= req_idx;
      we_r   <= I_WB_WE;
      sel_r  <= I_WB_SEL[0];
      wdat_r <= I_WB_DAT[7:0];
    end
  end

  always_comb
  begin
    tgt_c = idx_r;
    if (we_r && (idx_r == `BGP_IDX_BITOP))
    begin
      tgt_c = bitop_target(wdat_r[`BGP_BO_TGT_HI:`BGP_BO_TGT_LO]);
    end
  end

  // Whole-register read of the target, shared by bus reads and write-backs
  always_comb
  begin
    rd_val = 8'h00;
    if (is_status(tgt_c))
    begin
      rd_val = status_r;
    end
    else if (tgt_c == `BGP_IDX_PORT)
    begin
      rd_val = {`BGP_PORT_UPPER, pad_if.pins};
    end
    else if (tgt_c == `BGP_IDX_OPTION)
    begin
      rd_val = option_r;
    end
    else if (tgt_c == `BGP_IDX_DIR)
    begin
      rd_val = {`BGP_DIR_UPPER, dir_r};
    end
    else if (tgt_c == `BGP_IDX_BITOP)
    begin
      rd_val = bitop_r;
    end
    else if (gpr_hit(tgt_c))
    begin
      rd_val = gpr_r[gpr_slot(tgt_c)];
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      tgt_r     <= 8'h00;
      operand_r <= 8'h00;
    end
    else if (state_r == BGP_OPER)
    begin
      tgt_r     <= tgt_c;
      operand_r <= rd_val;
    end
  end

  // A lane-0-less write still rewrites the register with what was read
  always_comb
  begin
    result_c = operand_r;
    if (idx_r == `BGP_IDX_BITOP)
    begin
      if (sel_r)
      begin
        result_c = bit_apply(operand_r, wdat_r[`BGP_BO_BIT_HI:`BGP_BO_BIT_LO],
                             wdat_r[`BGP_BO_VAL]);
      end
    end
    else if (sel_r)
    begin
      result_c = wdat_r;
    end
  end

  assign commit = (state_r == BGP_ACK) && we_r;

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      status_r <= `BGP_STATUS_RST;
    end
    else if (commit && is_status(tgt_r))
    begin
      status_r <= (result_c & `BGP_STATUS_WMASK)
                | (status_r & ~`BGP_STATUS_WMASK);
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      option_r <= `BGP_OPTION_RST;
    end
    else if (commit && (tgt_r == `BGP_IDX_OPTION))
    begin
      option_r <= result_c;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      dir_r <= `BGP_DIR_RST;
    end
    else if (commit && (tgt_r == `BGP_IDX_DIR))
    begin
      dir_r <= result_c[5:0];
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      bitop_r <= 8'h00;
    end
    else if (commit && (idx_r == `BGP_IDX_BITOP) && sel_r)
    begin
      bitop_r <= wdat_r;
    end
  end

  // Data memory has no reset, like the static cells it stands for
  always_ff @(posedge I_REF_CLK)
  begin
    if (commit && gpr_hit(tgt_r))
    begin
      gpr_r[gpr_slot(tgt_r)] <= result_c;
    end
  end

  // Input bits carry their pin level back into the latch on bit-operation and lane-0-less port write-backs
  assign pad_if.wr_en   = commit && (tgt_r == `BGP_IDX_PORT);
  assign pad_if.wr_data = result_c[5:0];
  assign pad_if.dir     = dir_r;

  bgp_pad_bank u_pad
  (
    .i_clk     (I_REF_CLK),
    .i_rst     (I_RST),
    .i_por_rst (I_POR_RST),
    .pad       (pad_if),
    .i_pin     (I_GP),
    .o_pin     (O_GP),
    .o_pin_oe  (O_GP_OE)
  );

  assign O_WB_ACK         = (state_r == BGP_ACK);
  assign O_WB_DAT         = {`BGP_RD_PAD, operand_r};
  assign O_WEAK_PULLUP_EN = ~option_r[`BGP_OPT_PULLUP_N];

endmodule

`default_nettype wire

/* File: bgp_gpio_port_tb_top.sv */
// Testbench for the banked GPIO port
`timescale 1ns/1ps
`default_nettype none
module bgp_gpio_port_tb_top;
  logic        clk, rst, por, cyc, stb, we, ack, pu;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [5:0]  gp_in, gp_out, gp_oe, ext;
  logic [7:0]  d;
  int          n_fail, compares;
  bgp_gpio_port dut (.I_REF_CLK(clk), .I_RST(rst), .I_POR_RST(por),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_GP(gp_in), .O_GP(gp_out),
    .O_GP_OE(gp_oe), .O_WEAK_PULLUP_EN(pu));
  bgp_pin_model pins (.i_drv(gp_out), .i_oe(gp_oe), .i_ext(ext), .o_pin(gp_in));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Idle gap first, so pins settle through the synchroniser
  task automatic wb(logic w, logic [9:0] a, logic [7:0] v);
    int t;
    repeat (3) @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, v};
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (ack !== 1'b1 && t < 50);
    if (t >= 50)
      n_fail++;
    d = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    // Registers and latch move on the ack edge; let it settle before callers look
    @(posedge clk);
  endtask
  task automatic rd(string nm, logic [9:0] a, logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, e, d);
  endtask
  task automatic t_reset;
    rd("status", 10'h00C, 8'h18);
    rd("option", 10'h204, 8'hFF);
    rd("dir", 10'h214, 8'h3F);
    chk("oe", 8'h00, {2'b00, gp_oe});
    chk("latch", 8'h00, {2'b00, gp_out});
    $display("t_reset done");
  endtask
  task automatic t_port;
    wb(1'b1, 10'h214, 8'h38);
    wb(1'b1, 10'h014, 8'h2A);
    chk("oe", 8'h07, {2'b00, gp_oe});
    chk("latch", 8'h2A, {2'b00, gp_out});
    rd("port", 10'h014, 8'hEA);
    $display("t_port done");
  endtask
  task automatic t_rmw;
    ext <= 6'h38;
    wb(1'b1, 10'h01C, 8'h15);
    chk("latch", 8'h1A, {2'b00, gp_out});
    wb(1'b1, 10'h01C, 8'h14);
    wb(1'b1, 10'h214, 8'h07);
    chk("latch", 8'h2A, {2'b00, gp_out});
    $display("t_rmw done");
  endtask
  task automatic t_bitop;
    wb(1'b1, 10'h01C, 8'h08);
    rd("status", 10'h00C, 8'h19);
    wb(1'b1, 10'h01C, 8'h27);
    rd("option", 10'h204, 8'h7F);
    chk("pullup", 8'h01, {7'h00, pu});
    wb(1'b1, 10'h01C, 8'h30);
    rd("dir", 10'h214, 8'h06);
    chk("oe", 8'h39, {2'b00, gp_oe});
    $display("t_bitop done");
  endtask
  task automatic t_bank;
    wb(1'b1, 10'h00C, 8'h20);
    rd("bank1 dir", 10'h014, 8'h06);
    rd("status", 10'h00C, 8'h38);
    wb(1'b1, 10'h00C, 8'h00);
    rd("unmapped", 10'h018, 8'h00);
    $display("t_bank done");
  endtask
  task automatic t_mem;
    wb(1'b1, 10'h1C0, 8'h5A);
    rd("mirror", 10'h3C0, 8'h5A);
    wb(1'b1, 10'h080, 8'hC3);
    rd("mem", 10'h080, 8'hC3);
    $display("t_mem done");
  endtask
  task automatic t_warm;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("latch", 8'h2A, {2'b00, gp_out});
    rd("port", 10'h014, 8'hF8);
    // Lane 0 off: a pure rewrite, so every input pin lands in the latch
    sel <= 4'h0;
    wb(1'b1, 10'h014, 8'h00);
    sel <= 4'h1;
    chk("latch", 8'h38, {2'b00, gp_out});
    $display("t_warm done");
  endtask
  task automatic print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    {rst, por, cyc, stb, we} = 5'b11000;
    adr = 10'h000;
    sel = 4'h1;
    wdat = 32'h0000_0000;
    ext = 6'h28;
    n_fail = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    t_reset();
    t_port();
    t_rmw();
    t_bitop();
    t_bank();
    t_mem();
    t_warm();
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: bgp_pad_bank.sv */
// Pin bank: input synchroniser, output latch and drivers for the six port pins
`timescale 1ns/1ps
`default_nettype none
`include "bgp_cfg.svh"

module bgp_pad_bank
  import bgp_pkg::*;
(
  // Clock and resets
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_por_rst,
  // Core side
  bgp_pad_if.pad           pad,
  // Pins
  input  wire logic [5:0]  i_pin,
  output logic [5:0]       o_pin,
  output logic [5:0]       o_pin_oe
);

  logic [5:0] meta_r;
  logic [5:0] sync_r;
  logic [5:0] latch_r;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_r <= 6'h00;
      sync_r <= 6'h00;
    end
    else
    begin
      meta_r <= i_pin;
      sync_r <= meta_r;
    end
  end

  // Only power-on clears the latch; other resets leave the pin data alone
  always_ff @(posedge i_clk or posedge i_por_rst)
  begin
    if (i_por_rst)
    begin
      latch_r <= `BGP_LATCH_POR;
    end
    else if (pad.wr_en)
    begin
      latch_r <= pad.wr_data;
    end
  end

  assign pad.pins  = sync_r;
  assign pad.latch = latch_r;
  assign o_pin     = latch_r;
  assign o_pin_oe  = ~pad.dir;

endmodule

`default_nettype wire

/* File: bgp_pad_if.sv */
// Interface between the register core and the pin bank
`timescale 1ns/1ps
`default_nettype none

interface bgp_pad_if;
  logic [5:0] dir;
  logic       wr_en;
  logic [5:0] wr_data;
  logic [5:0] pins;
  logic [5:0] latch;

  modport core
  (
    output dir,
    output wr_en,
    output wr_data,
    input  pins,
    input  latch
  );

  modport pad
  (
    input  dir,
    input  wr_en,
    input  wr_data,
    output pins,
    output latch
  );
endinterface

`default_nettype wire

/* File: bgp_pin_model.sv */
// Board-side model of the six port pins
`timescale 1ns/1ps
`default_nettype none
module bgp_pin_model
(
  // Device side
  input  wire logic [5:0] i_drv,
  input  wire logic [5:0] i_oe,
  // Board side
  input  wire logic [5:0] i_ext,
  output logic [5:0]      o_pin
);
  // Board drives only the pins the device leaves as inputs
  assign o_pin = (i_oe & i_drv) | (~i_oe & i_ext);
endmodule
`default_nettype wire

/* File: bgp_pkg.sv */
// Types shared by the banked GPIO port modules
package bgp_pkg;

  typedef enum logic [1:0]
  {
    BGP_IDLE,
    BGP_OPER,
    BGP_ACK
  } bgp_state_type;

  typedef enum logic [1:0]
  {
    BGP_TGT_STATUS,
    BGP_TGT_PORT,
    BGP_TGT_OPTION,
    BGP_TGT_DIR
  } bgp_target_type;

endpackage
